// ### inc/wdc_pkg.sv
// constants, types and helpers shared by the watchdog with dual clear
//
// Notes on behaviour
// - counter clock is either the 32 kHz sub clock or the core clock divided by four
// - with the watchdog option off, every watchdog clear instruction does nothing
// - four-bit key disables the watchdog only at 1010; other values keep it enabled
// - key field starts at 1010 after power-on, so the watchdog starts disabled
// - time-out divides the source clock by 2^13 to 2^16, chosen by option
// - a clear instruction or halt resets only the last divider stage; time-out varies up to twice
// - core-clock source stops counting during power-down
// - time-out in normal running requests a full reset and sets the expired flag
// - time-out in power-down sets the expired flag, resets only counter and stack pointer
// - external reset low, clear instructions, or halt clear the watchdog count
// - single mode: one single clear instruction clears at once
// - dual mode: clearing needs both the first and the second clear instruction
// - dual mode: repeated first clears add nothing; a second clear is still needed
// - dual mode: after a second clear, only a first clear completes the pair
// - halt clears the watchdog, sets the sleep flag and clears the expired flag
// - every wake-up from power-down waits 1024 system clocks before running
package wdc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_KEY = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    // software key: the one value that switches the watchdog off, and its power-on value
    localparam logic [3:0] KEY_DISABLE = 4'ha;
    localparam logic [3:0] KEY_RESET = 4'ha;
    // status register bit positions
    localparam int ST_EXPIRED = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_DOWN = 2;
    localparam int ST_WAKE = 3;
    localparam int ST_ENABLED = 4;
    localparam int ST_W = 5;
    // interrupt status and mask bit positions
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_W = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    // core clock prescaler for the counter source
    localparam int CORE_DIV = 4;
    localparam logic [1:0] CORE_DIV_LAST = 2'(CORE_DIV - 1);
    // wake-up wait in system clock periods
    localparam int WAKE_CYCLES = 1024;
    localparam int WAKE_W = 10;
    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
    // divider chain length: 2^16 is the longest ratio
    localparam int CHAIN_W = 16;
    // configuration option encodings
    localparam logic CLK_SRC_SUB = 1'b0;
    localparam logic CLK_SRC_CORE = 1'b1;
    localparam logic CLR_MODE_SINGLE = 1'b0;
    localparam logic CLR_MODE_DUAL = 1'b1;

    typedef enum logic [1:0] {
        WDC_PS_RUN = 2'b00,
        WDC_PS_DOWN = 2'b01,
        WDC_PS_WAKE = 2'b10
    } wdc_pstate_t;

    typedef enum logic [1:0] {
        WDC_DQ_NONE = 2'b00,
        WDC_DQ_FIRST = 2'b01,
        WDC_DQ_SECOND = 2'b10
    } wdc_dual_t;

    // true when the software key holds the disabling pattern
    function automatic logic wdc_key_off(input logic [3:0] key);
        return key == KEY_DISABLE;
    endfunction : wdc_key_off
endpackage : wdc_pkg

// ### inc/wdc_div_if.sv
// control and result signals between the watchdog core and its divider chain
interface wdc_div_if;
    logic tick;
    logic clear_last;
    logic clear_all;
    logic [1:0] tap_sel;
    logic overflow;
    logic last_stage;
    logic [wdc_pkg::CHAIN_W-2:0] low_count;
    modport ctl (output tick, output clear_last, output clear_all, output tap_sel,
                 input overflow, input last_stage, input low_count);
    modport div (input tick, input clear_last, input clear_all, input tap_sel,
                 output overflow, output last_stage, output low_count);
endinterface : wdc_div_if

// ### hw/wdc_divider.sv
// watchdog divider chain: free lower stages plus one clearable last stage
module wdc_divider #(
    parameter int CHAIN_W = wdc_pkg::CHAIN_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    wdc_div_if.div dif
);
    localparam int LOW_W = CHAIN_W - 1;

    generate
        if (CHAIN_W < 5) begin : g_chk
            $error("divider chain too short for four tap settings");
        end
    endgenerate

    logic [LOW_W-1:0] low_reg;
    logic last_reg;
    logic [LOW_W-1:0] tap_mask;
    logic wrap;

    // tap 0 wraps the lower stages every 2^(CHAIN_W-4), tap 3 every 2^(CHAIN_W-1)
    assign tap_mask = {LOW_W{1'b1}} >> (2'h3 - dif.tap_sel);
    assign wrap = dif.tick && ((low_reg & tap_mask) == tap_mask);
    assign dif.overflow = wrap && last_reg;
    assign dif.last_stage = last_reg;
    assign dif.low_count = low_reg;

    // lower stages: only a full clear touches them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_reg <= '0;
        end else if (dif.clear_all) begin
            low_reg <= '0;
        end else if (dif.tick) begin
            low_reg <= low_reg + 1'b1;
        end
    end

    // last stage: the clear instructions reset this bit alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_reg <= 1'b0;
        end else if (dif.clear_all || dif.clear_last) begin
            last_reg <= 1'b0;
        end else if (wrap) begin
            last_reg <= ~last_reg;
        end
    end

    AST_LOW_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
        (dif.clear_last && !dif.clear_all && !dif.tick) |=> (low_reg == $past(low_reg)))
        else $error("last-stage clear disturbed the lower divider stages");
endmodule : wdc_divider

// ### hw/wdc_watchdog.sv
// watchdog timer with single or dual clear, power-down handling and AHB-Lite registers
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
module wdc_watchdog (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cfg_wd_enable,
    input wire logic cfg_clk_src,
    input wire logic cfg_clear_mode,
    input wire logic [1:0] cfg_tap_sel,
    input wire logic sub_clk_in,
    input wire logic ext_rst_n,
    input wire logic wake_req,
    input wire logic wd_clear_single,
    input wire logic wd_clear_first,
    input wire logic wd_clear_second,
    input wire logic cpu_halt,
    output logic sys_reset_req,
    output logic pc_sp_reset,
    output logic core_hold,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    wdc_div_if dif ();

    logic [3:0] wd_disable_key_reg;
    logic watchdog_expired_flag_reg;
    logic sleep_entered_flag_reg;
    logic [wdc_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [wdc_pkg::IRQ_W-1:0] irq_mask_reg;
    wdc_pkg::wdc_pstate_t pstate_reg;
    wdc_pkg::wdc_dual_t dual_reg;
    wdc_pkg::wdc_dual_t dual_next;
    logic [wdc_pkg::WAKE_W-1:0] wake_cnt_reg;
    logic [1:0] core_div_reg;
    logic sys_reset_req_reg;
    logic pc_sp_reset_reg;
    logic [2:0] sub_sync_reg;
    logic [1:0] ext_sync_reg;
    logic [1:0] wake_sync_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;

    logic wd_enabled;
    logic instr_ok;
    logic ext_rst_active;
    logic single_clr;
    logic dual_done;
    logic halt_take;
    logic sub_tick;
    logic core_tick;
    logic timeout_run;
    logic timeout_down;
    logic wake_event;
    logic wake_done;
    logic ap_take;
    logic [wdc_pkg::IRQ_W-1:0] irq_events;
    logic [wdc_pkg::ST_W-1:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // the sub clock, reset pin and wake pin are all foreign to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_sync_reg <= 3'h0;
            ext_sync_reg <= 2'h3;
            wake_sync_reg <= 2'h0;
        end else begin
            sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_in};
            ext_sync_reg <= {ext_sync_reg[0], ext_rst_n};
            wake_sync_reg <= {wake_sync_reg[0], wake_req};
        end
    end

    // edge detect looks only at the second and third stages
    assign sub_tick = sub_sync_reg[1] && !sub_sync_reg[2];
    assign ext_rst_active = !ext_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // enables and clear decoding

    // the key can only switch off a watchdog the option left on
    assign wd_enabled = cfg_wd_enable && !wdc_pkg::wdc_key_off(wd_disable_key_reg);
    assign instr_ok = cfg_wd_enable;
    assign halt_take = cpu_halt && (pstate_reg == wdc_pkg::WDC_PS_RUN);
    assign single_clr = instr_ok && (cfg_clear_mode == wdc_pkg::CLR_MODE_SINGLE) && wd_clear_single;

    // dual-clear tracker: the two instructions must alternate to complete a pair
    always_comb begin
        dual_next = dual_reg;
        dual_done = 1'b0;
        if (instr_ok && (cfg_clear_mode == wdc_pkg::CLR_MODE_DUAL)) begin
            case (dual_reg)
                wdc_pkg::WDC_DQ_NONE: begin
                    if (wd_clear_first) begin
                        dual_next = wdc_pkg::WDC_DQ_FIRST;
                    end else if (wd_clear_second) begin
                        dual_next = wdc_pkg::WDC_DQ_SECOND;
                    end
                end
                wdc_pkg::WDC_DQ_FIRST: begin
                    // another first clear here leaves the tracker where it is
                    if (wd_clear_second) begin
                        dual_done = 1'b1;
                        dual_next = wdc_pkg::WDC_DQ_NONE;
                    end
                end
                wdc_pkg::WDC_DQ_SECOND: begin
                    if (wd_clear_first) begin
                        dual_done = 1'b1;
                        dual_next = wdc_pkg::WDC_DQ_NONE;
                    end
                end
                default: begin
                    dual_next = wdc_pkg::WDC_DQ_NONE;
                end
            endcase
        end
        if (ext_rst_active || (halt_take && instr_ok)) begin
            dual_next = wdc_pkg::WDC_DQ_NONE;
            dual_done = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dual_reg <= wdc_pkg::WDC_DQ_NONE;
        end else begin
            dual_reg <= dual_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter source and divider chain

    // core clock prescaler halts with the core in power-down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_div_reg <= 2'h0;
        end else if (pstate_reg == wdc_pkg::WDC_PS_RUN) begin
            core_div_reg <= core_div_reg + 2'h1;
        end
    end

    assign core_tick = (pstate_reg == wdc_pkg::WDC_PS_RUN) && (core_div_reg == wdc_pkg::CORE_DIV_LAST);

    assign dif.tick = wd_enabled && ((cfg_clk_src == wdc_pkg::CLK_SRC_CORE) ? core_tick : sub_tick);
    assign dif.tap_sel = cfg_tap_sel;
    assign dif.clear_last = single_clr || dual_done || (halt_take && instr_ok);
    // the chain restarts whole with a device reset, whether from the pin or a time-out
    assign dif.clear_all = ext_rst_active || sys_reset_req_reg;

    wdc_divider #(
        .CHAIN_W(wdc_pkg::CHAIN_W)
    ) u_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .dif(dif)
    );

    assign timeout_run = dif.overflow && (pstate_reg == wdc_pkg::WDC_PS_RUN);
    assign timeout_down = dif.overflow && (pstate_reg != wdc_pkg::WDC_PS_RUN);

    ////////////////////////////////////////////////////////////////////////////////
    // reset requests and flags

    // one-cycle reset requests toward the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset_req_reg <= 1'b0;
            pc_sp_reset_reg <= 1'b0;
        end else begin
            sys_reset_req_reg <= timeout_run;
            pc_sp_reset_reg <= timeout_down;
        end
    end

    // expired flag: a time-out in the same cycle as a halt wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_expired_flag_reg <= 1'b0;
        end else if (dif.overflow) begin
            watchdog_expired_flag_reg <= 1'b1;
        end else if (halt_take) begin
            watchdog_expired_flag_reg <= 1'b0;
        end
    end

    // sleep flag: set by halt, dropped by a completed clear instruction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_entered_flag_reg <= 1'b0;
        end else if (halt_take) begin
            sleep_entered_flag_reg <= 1'b1;
        end else if (single_clr || dual_done) begin
            sleep_entered_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state: run, power-down, wake-up wait

    assign wake_event = wake_sync_reg[1] || timeout_down || ext_rst_active;
    assign wake_done = (pstate_reg == wdc_pkg::WDC_PS_WAKE) && (wake_cnt_reg == wdc_pkg::WAKE_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pstate_reg <= wdc_pkg::WDC_PS_RUN;
        end else begin
            case (pstate_reg)
                wdc_pkg::WDC_PS_RUN: begin
                    if (halt_take) begin
                        pstate_reg <= wdc_pkg::WDC_PS_DOWN;
                    end
                end
                wdc_pkg::WDC_PS_DOWN: begin
                    if (wake_event) begin
                        pstate_reg <= wdc_pkg::WDC_PS_WAKE;
                    end
                end
                wdc_pkg::WDC_PS_WAKE: begin
                    if (wake_done) begin
                        pstate_reg <= wdc_pkg::WDC_PS_RUN;
                    end
                end
                default: begin
                    pstate_reg <= wdc_pkg::WDC_PS_RUN;
                end
            endcase
        end
    end

    // wake wait counter: counts from zero on each entry into the wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_cnt_reg <= '0;
        end else if (pstate_reg == wdc_pkg::WDC_PS_WAKE) begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
        end else begin
            wake_cnt_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave and registers

    assign ap_take = hsel && htrans[1] && hready;
    assign status_word = {wd_enabled, pstate_reg == wdc_pkg::WDC_PS_WAKE, pstate_reg == wdc_pkg::WDC_PS_DOWN,
                          sleep_entered_flag_reg, watchdog_expired_flag_reg};

    // read data is fetched in the address phase so it stands from a flop in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            dp_write_reg <= ap_take && hwrite;
            dp_addr_reg <= haddr[7:0];
            if (ap_take && !hwrite) begin
                case (haddr[7:0])
                    wdc_pkg::ADDR_KEY: hrdata_reg <= {28'h0000000, wd_disable_key_reg};
                    wdc_pkg::ADDR_STATUS: hrdata_reg <= {27'h0000000, status_word};
                    wdc_pkg::ADDR_IRQ_STAT: hrdata_reg <= {30'h00000000, irq_stat_reg};
                    wdc_pkg::ADDR_IRQ_MASK: hrdata_reg <= {30'h00000000, irq_mask_reg};
                    default: hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // key register: power-on value keeps the watchdog off until software changes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_disable_key_reg <= wdc_pkg::KEY_RESET;
        end else if (dp_write_reg && (dp_addr_reg == wdc_pkg::ADDR_KEY)) begin
            wd_disable_key_reg <= hwdata[3:0];
        end
    end

    // interrupt status: write one to clear, a new event in the same cycle wins
    assign irq_events = {wake_done, dif.overflow};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= wdc_pkg::IRQ_RESET;
        end else if (dp_write_reg && (dp_addr_reg == wdc_pkg::ADDR_IRQ_STAT)) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[wdc_pkg::IRQ_W-1:0]) | irq_events;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= wdc_pkg::IRQ_RESET;
        end else if (dp_write_reg && (dp_addr_reg == wdc_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_reg <= hwdata[wdc_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states: every transfer is answered at once with OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign sys_reset_req = sys_reset_req_reg;
    assign pc_sp_reset = pc_sp_reset_reg;
    assign core_hold = (pstate_reg != wdc_pkg::WDC_PS_RUN);
    assign irq = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_dual_first;
        (dual_reg == wdc_pkg::WDC_DQ_FIRST) && !ext_rst_active && !cpu_halt && instr_ok
            && (cfg_clear_mode == wdc_pkg::CLR_MODE_DUAL);
    endsequence

    sequence s_pair_done;
        dif.clear_last ##1 (dual_reg == wdc_pkg::WDC_DQ_NONE);
    endsequence

    AST_KEY_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        wdc_pkg::wdc_key_off(wd_disable_key_reg) |-> !dif.tick)
        else $error("watchdog counted while the key disabled it");

    AST_NO_OPTION: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg_wd_enable |-> (!dif.clear_last && !dif.tick))
        else $error("clear or count acted with the watchdog option off");

    AST_CORE_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
        ((cfg_clk_src == wdc_pkg::CLK_SRC_CORE) && core_hold) |-> !dif.tick)
        else $error("core-clock source ticked during power-down");

    AST_TIMEOUT_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        (dif.overflow && !core_hold) |=> (sys_reset_req && !pc_sp_reset && watchdog_expired_flag_reg))
        else $error("time-out in run did not request a full reset with the flag");

    AST_TIMEOUT_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
        (dif.overflow && core_hold) |=> (pc_sp_reset && !sys_reset_req && watchdog_expired_flag_reg))
        else $error("time-out in power-down gave the wrong reset");

    AST_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (wd_clear_single && cfg_wd_enable && (cfg_clear_mode == wdc_pkg::CLR_MODE_SINGLE))
            |-> dif.clear_last ##1 !dif.last_stage)
        else $error("single clear did not clear the last stage");

    AST_FIRST_REPEAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_dual_first and (wd_clear_first && !wd_clear_second)) |-> !dif.clear_last ##1
            (dual_reg == wdc_pkg::WDC_DQ_FIRST))
        else $error("repeated first clear changed the dual tracker");

    AST_PAIR: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_dual_first and wd_clear_second) |-> s_pair_done)
        else $error("first then second clear did not clear the watchdog");

    AST_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
        (halt_take && cfg_wd_enable && !dif.overflow) |-> dif.clear_last ##1
            (sleep_entered_flag_reg && !watchdog_expired_flag_reg && core_hold))
        else $error("halt did not clear the watchdog and set the flags");

    AST_WAKE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        ((pstate_reg == wdc_pkg::WDC_PS_WAKE) && !wake_done) |=> (core_hold && (wake_cnt_reg == $past(wake_cnt_reg) + 1'b1)))
        else $error("wake-up wait ended early or stalled");

    AST_WAKE_END: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_done |=> (!core_hold && (wake_cnt_reg == '0)))
        else $error("core not released after the wake-up wait");

    AST_EXT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_rst_active |=> ((dif.low_count == '0) && !dif.last_stage && (dual_reg == wdc_pkg::WDC_DQ_NONE)))
        else $error("external reset did not clear the count and tracker");
endmodule : wdc_watchdog

// ### sim/wdc_cpu_model.sv
// cpu core model issuing one watchdog instruction per command
module wdc_cpu_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] op,
    output logic wd_clear_single,
    output logic wd_clear_first,
    output logic wd_clear_second,
    output logic cpu_halt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pulse_reg;
    // op 1 single, 2 first, 3 second, 4 halt; each lasts one cycle so nothing repeats by accident
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_reg <= 4'h0;
        end else begin
            pulse_reg <= (op == 3'h0) ? 4'h0 : 4'(4'h1 << (op - 3'h1));
        end
    end
    assign {cpu_halt, wd_clear_second, wd_clear_first, wd_clear_single} = pulse_reg;
endmodule : wdc_cpu_model

// ### sim/tb_watchdog_timer_with_dual_clear.sv
// self-checking bench for the watchdog with dual clear
module tb_watchdog_timer_with_dual_clear;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = '0, hresetn = '0, hsel = '1, hwrite = '0, sub_clk_in = '0, ext_rst_n = '1, wake_req = '0;
    logic cfg_wd_enable = '1, cfg_clk_src = '1, cfg_clear_mode = '0;
    logic [1:0] htrans = '0, cfg_tap_sel = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [2:0] op = '0;
    logic hreadyout, hresp, sys_reset_req, pc_sp_reset, core_hold, irq;
    logic wd_clear_single, wd_clear_first, wd_clear_second, cpu_halt;
    int num_errors = 0, cmp_count = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // core clock and an unrelated slow sub clock
    always #5 hclk = ~hclk;
    always #15625 sub_clk_in = ~sub_clk_in;
    wdc_watchdog DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cfg_wd_enable, .cfg_clk_src, .cfg_clear_mode,
        .cfg_tap_sel, .sub_clk_in, .ext_rst_n, .wake_req, .wd_clear_single, .wd_clear_first,
        .wd_clear_second, .cpu_halt, .sys_reset_req, .pc_sp_reset, .core_hold, .irq);
    wdc_cpu_model CPU (.hclk, .hresetn, .op, .wd_clear_single, .wd_clear_first, .wd_clear_second, .cpu_halt);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk
    // one single word transfer; read data lands in r at the end of the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic ins(input logic [2:0] c);
        op <= c;
        @(posedge hclk);
        op <= 3'h0;
        repeat (2) @(posedge hclk);
    endtask : ins
    // halt, check the sleep state, then wake by pin or by wake source and time the hold
    task automatic nap(input logic ext);
        int n = 0;
        ins(3'h4);
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("status after halt", 32'h6, r & 32'h7);
        if (ext) ext_rst_n <= 1'h0;
        else wake_req <= 1'h1;
        @(posedge hclk);
        ext_rst_n <= 1'h1;
        wake_req <= 1'h0;
        while (core_hold === 1'h1 && n < 1100) begin
            @(posedge hclk);
            n++;
        end
        chk("wake wait", 32'h1, {31'h0, n >= 1024 && n <= 1032});
    endtask : nap
    // halt, two instructions, look at the sleep flag, a third, look again
    task automatic seq(input logic m, input logic [2:0] a, b, c, input logic [31:0] e1, e2);
        cfg_clear_mode <= m;
        nap(1'h0);
        ins(a);
        ins(b);
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("sleep after two", e1, r & 32'h2);
        ins(c);
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("sleep after three", e2, r & 32'h2);
    endtask : seq
    task automatic results();
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; the time-out runs first while the divider is still fresh from reset
    initial begin
        int n = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, wdc_pkg::ADDR_KEY, 32'h0);
        chk("key reset", 32'ha, r);
        bus(1'h0, 8'h10, 32'h0);
        chk("unmapped read", 32'h0, r);
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("enabled off", 32'h0, r & 32'h10);
        bus(1'h1, wdc_pkg::ADDR_IRQ_MASK, 32'h1);
        bus(1'h1, wdc_pkg::ADDR_KEY, 32'h5);
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("enabled on", 32'h10, r & 32'h10);
        while (sys_reset_req !== 1'h1 && n < 33000) begin
            @(posedge hclk);
            n++;
        end
        chk("time-out moment", 32'h1, {31'h0, n > 32700 && n < 32800});
        chk("no pc reset in run", 32'h0, {31'h0, pc_sp_reset});
        bus(1'h0, wdc_pkg::ADDR_STATUS, 32'h0);
        chk("expired flag", 32'h1, r & 32'h1);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'h1, wdc_pkg::ADDR_IRQ_STAT, 32'h1);
        // the clear lands at the edge that ends the data phase; look one edge later
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'h1, wdc_pkg::ADDR_KEY, 32'ha);
        nap(1'h1);
        seq(1'h1, 3'h2, 3'h2, 3'h3, 32'h2, 32'h0);
        seq(1'h1, 3'h1, 3'h2, 3'h1, 32'h2, 32'h2);
        seq(1'h1, 3'h3, 3'h3, 3'h2, 32'h2, 32'h0);
        seq(1'h0, 3'h2, 3'h3, 3'h1, 32'h2, 32'h0);
        cfg_wd_enable <= 1'h0;
        seq(1'h0, 3'h1, 3'h1, 3'h1, 32'h2, 32'h2);
        results();
    end
    // the run needs about 40000 cycles; cut a hang short well beyond that
    initial begin
        #600000;
        num_errors++;
        results();
    end
endmodule : tb_watchdog_timer_with_dual_clear
